// File: src/dchannel_link_config_regs.sv
// apb register bank that configures the d-channel link controller
//
// How it works
// - transmit address enable in mode one bit 2 sends transmit_address as outgoing address
// - first-byte match registers compared to first address byte; ignored when pair disabled
// - writes seed the random generator; reads return the generated value
// - mode one bits 0 and 1 enable transmit and receive threshold interrupts
// - mode one bit 3 enables end-of-receive-packet interrupt; off after reset
// - mode registers change only under software writes and raise no interrupts
// - error mask bit n enables error flag bit n; all off after reset
// - status mask bits 0 and 1 enable address and end-of-transmit interrupts; on after reset
// - status mask bits 2..6 enable the five status interrupts; off after reset
// - status mask bit 7 passes received check bytes into the receive fifo
// - mode four bits 1:0 select receive threshold, normal or extended table
// - mode four bits 3:2 select transmit threshold, normal or extended table
// - mode four bit 4 picks interframe fill: ones or flags
// - mode four bit 5 selects one-byte matching; bit 7 picks which byte
// - mode four bit 6 includes the command/response bit in the first compare
// - transmit port is write-only pushing bytes; receive port read-only popping bytes
// - transmit byte count is read/write and tracks bytes left in the packet
`timescale 1ns/100ps
module dchannel_link_config_regs
	import dchannel_link_pkg::*;
#(
	parameter int ADDR_W = 12 // apb byte address width
) (
	input wire logic clk, // 20 MHz device clock
	input wire logic reset_n, // synchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction, high writes
	input wire logic [ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error, unmapped address
	input wire rx_addr_byte_t rxAddrByte, // received address byte
	input wire logic [15:0] rxByteCount, // receive byte count from the controller
	input wire logic [7:0] rxFifoData, // head byte of the receive fifo
	input wire logic txByteDone, // one byte moved from transmit fifo to the controller
	output link_cfg_t linkCfg, // decoded configuration
	output logic [3:0] matchFlags, // pairs that recognised the address
	output logic addressDone, // pulse, address evaluation finished
	output logic [15:0] txByteCount, // bytes left in the transmit packet
	output logic txPush, // pulse, push txData into the transmit fifo
	output logic [7:0] txData, // byte pushed to the transmit fifo
	output logic rxPop // pulse, pop the receive fifo
);
	localparam int IW = ADDR_W - 2;

	// the decode needs all eight index bits
	if (ADDR_W < 10) begin : g_addr_check
		$error("ADDR_W must be at least 10");
	end

	typedef struct packed {
		logic ready;
		logic slvErr;
		logic [31:0] rdata;
		logic [NUM_PAIRS-1:0][7:0] firstMatch;
		logic [NUM_PAIRS-1:0][7:0] secondMatch;
		logic [1:0] firstPtr;
		logic [1:0] secondPtr;
		logic [15:0] txAddr;
		logic [15:0] txCount;
		logic [7:0] modeOne;
		logic [7:0] errorMask;
		logic [7:0] statusMask;
		logic [7:0] fifoMode;
		logic extFifo;
		logic [15:0] rng;
		logic [NUM_PAIRS-1:0] firstHit;
		logic [NUM_PAIRS-1:0] match;
		logic addrDone;
		logic push;
		logic [7:0] pushData;
		logic pop;
		link_cfg_t cfg;
	} bank_state_t;

	bank_state_t st;
	bank_state_t next_st;

	logic [IW-1:0] wordIdx;
	logic aligned;
	logic xfer;
	logic wrXfer;
	logic rdXfer;
	logic [7:0] cmpMask;
	logic [NUM_PAIRS-1:0] firstEq;
	logic [NUM_PAIRS-1:0] secondEq;
	logic [NUM_PAIRS-1:0] pairEn;

	// apb decode; a transfer completes on the edge where registered ready is high
	assign wordIdx = paddr[ADDR_W-1:2];
	assign aligned = (paddr[1:0] == 2'h0);
	assign xfer = psel && penable && st.ready;
	assign wrXfer = xfer && pwrite;
	assign rdXfer = xfer && !pwrite;

	// command/response bit is masked out of the first compare unless asked for
	assign cmpMask = st.cfg.crCompare ? CR_MASK_ON : CR_MASK_OFF;
	assign pairEn = st.modeOne[M1_PAIR_EN +: NUM_PAIRS];

	// per-pair comparators against the incoming byte
	for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
		assign firstEq[i] = ((rxAddrByte.data ^ st.firstMatch[i]) & cmpMask) == 8'h00;
		assign secondEq[i] = (rxAddrByte.data == st.secondMatch[i]);
	end

	// address hit test for a word index
	function automatic logic hit(input logic [IW-1:0] idx, input logic [7:0] reg_idx);
		hit = aligned && (idx == IW'(reg_idx));
	endfunction

	// next-state logic: bus slave, register writes, address match, random source
	always_comb begin
		next_st = st;
		next_st.push = 1'b0;
		next_st.pop = 1'b0;
		next_st.addrDone = 1'b0;

		// random source runs every cycle; xnor feedback keeps zero out of lockup
		next_st.rng = {st.rng[14:0], ~(^(st.rng & RNG_TAPS))};

		// transmit count follows bytes taken by the controller
		if (txByteDone && st.txCount != 16'h0000) begin
			next_st.txCount = st.txCount - 16'h0001;
		end

		// access phase: one wait state, then ready with data and error
		if (psel && penable && !st.ready) begin
			next_st.ready = 1'b1;
			next_st.slvErr = 1'b0;
			next_st.rdata = 32'h0000_0000;
			if (hit(wordIdx, IDX_FIRST_MATCH)) begin
				next_st.rdata[7:0] = st.firstMatch[st.firstPtr];
			end else if (hit(wordIdx, IDX_SECOND_MATCH)) begin
				next_st.rdata[7:0] = st.secondMatch[st.secondPtr];
			end else if (hit(wordIdx, IDX_TX_ADDRESS)) begin
				next_st.rdata[15:0] = st.txAddr;
			end else if (hit(wordIdx, IDX_TX_COUNT)) begin
				next_st.rdata[15:0] = st.txCount;
			end else if (hit(wordIdx, IDX_MODE_ONE)) begin
				next_st.rdata[7:0] = st.modeOne;
			end else if (hit(wordIdx, IDX_ERROR_MASK)) begin
				next_st.rdata[7:0] = st.errorMask;
			end else if (hit(wordIdx, IDX_RX_COUNT)) begin
				next_st.rdata[15:0] = rxByteCount;
			end else if (hit(wordIdx, IDX_RANDOM_LOW)) begin
				next_st.rdata[7:0] = st.rng[7:0];
			end else if (hit(wordIdx, IDX_RANDOM_HIGH)) begin
				next_st.rdata[7:0] = st.rng[15:8];
			end else if (hit(wordIdx, IDX_FIRST_MATCH_4)) begin
				next_st.rdata[7:0] = st.firstMatch[3];
			end else if (hit(wordIdx, IDX_SECOND_MATCH_4)) begin
				next_st.rdata[7:0] = st.secondMatch[3];
			end else if (hit(wordIdx, IDX_STATUS_MASK)) begin
				next_st.rdata[7:0] = st.statusMask;
			end else if (hit(wordIdx, IDX_FIFO_MODE)) begin
				next_st.rdata[7:0] = st.fifoMode;
			end else if (hit(wordIdx, IDX_EXT_FIFO)) begin
				next_st.rdata[0] = st.extFifo;
			end else if (hit(wordIdx, IDX_RX_PORT)) begin
				next_st.rdata[7:0] = rxFifoData;
			end else if (hit(wordIdx, IDX_TX_PORT)) begin
				next_st.rdata = 32'h0000_0000; // write-only port reads zero
			end else begin
				next_st.slvErr = 1'b1;
			end
		end else begin
			next_st.ready = 1'b0;
			next_st.slvErr = 1'b0;
		end

		// completing edge: writes land, indirect pointers step, ports strobe
		if (xfer) begin
			if (hit(wordIdx, IDX_FIRST_MATCH)) begin
				if (pwrite) begin
					next_st.firstMatch[st.firstPtr] = pwdata[7:0];
				end
				next_st.firstPtr = (st.firstPtr == SHARED_LAST) ? 2'h0 : st.firstPtr + 2'h1;
			end
			if (hit(wordIdx, IDX_SECOND_MATCH)) begin
				if (pwrite) begin
					next_st.secondMatch[st.secondPtr] = pwdata[7:0];
				end
				next_st.secondPtr = (st.secondPtr == SHARED_LAST) ? 2'h0 : st.secondPtr + 2'h1;
			end
			if (rdXfer && hit(wordIdx, IDX_RX_PORT)) begin
				next_st.pop = 1'b1;
			end
		end
		// mode registers have no path other than this write decode
		if (wrXfer) begin
			if (hit(wordIdx, IDX_TX_ADDRESS)) begin
				next_st.txAddr = pwdata[15:0];
			end
			if (hit(wordIdx, IDX_TX_COUNT)) begin
				next_st.txCount = pwdata[15:0];
			end
			if (hit(wordIdx, IDX_MODE_ONE)) begin
				next_st.modeOne = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_ERROR_MASK)) begin
				next_st.errorMask = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_RANDOM_LOW)) begin
				next_st.rng[7:0] = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_RANDOM_HIGH)) begin
				next_st.rng[15:8] = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_FIRST_MATCH_4)) begin
				next_st.firstMatch[3] = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_SECOND_MATCH_4)) begin
				next_st.secondMatch[3] = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_STATUS_MASK)) begin
				next_st.statusMask = pwdata[7:0];
			end
			// thresholds are not guarded; software keeps them still outside idle
			if (hit(wordIdx, IDX_FIFO_MODE)) begin
				next_st.fifoMode = pwdata[7:0];
			end
			if (hit(wordIdx, IDX_EXT_FIFO)) begin
				next_st.extFifo = pwdata[0];
			end
			if (hit(wordIdx, IDX_TX_PORT)) begin
				next_st.push = 1'b1;
				next_st.pushData = pwdata[7:0];
			end
		end

		// address recognition: flags settle on the second byte
		if (rxAddrByte.valid && !rxAddrByte.second) begin
			next_st.firstHit = firstEq;
			next_st.match = '0;
		end else if (rxAddrByte.valid) begin
			next_st.addrDone = 1'b1;
			if (!st.cfg.oneByteAddr) begin
				next_st.match = st.firstHit & secondEq & pairEn;
			end else if (st.cfg.secondByteOnly) begin
				next_st.match = secondEq & pairEn;
			end else begin
				next_st.match = st.firstHit & pairEn;
			end
		end

		// registered decode of the settings for the controller
		next_st.cfg.txThrIntEn = next_st.modeOne[M1_TX_THR_IE];
		next_st.cfg.rxThrIntEn = next_st.modeOne[M1_RX_THR_IE];
		next_st.cfg.eorIntEn = next_st.modeOne[M1_EOR_IE];
		next_st.cfg.txAddrEnable = next_st.modeOne[M1_TX_ADDR_EN];
		next_st.cfg.txAddress = next_st.txAddr;
		next_st.cfg.errorIntMask = next_st.errorMask;
		next_st.cfg.statusIntMask = next_st.statusMask[6:0];
		next_st.cfg.fcsToFifo = next_st.statusMask[M3_FCS_TO_FIFO];
		next_st.cfg.rxThreshold = next_st.extFifo ? RX_THR_EXT[next_st.fifoMode[M4_RX_THR +: 2]]
			: RX_THR_NORM[next_st.fifoMode[M4_RX_THR +: 2]];
		next_st.cfg.txThreshold = next_st.extFifo ? TX_THR_EXT[next_st.fifoMode[M4_TX_THR +: 2]]
			: TX_THR_NORM[next_st.fifoMode[M4_TX_THR +: 2]];
		next_st.cfg.flagIdle = next_st.fifoMode[M4_FLAG_IDLE];
		next_st.cfg.oneByteAddr = next_st.fifoMode[M4_ONE_BYTE];
		next_st.cfg.secondByteOnly = next_st.fifoMode[M4_SECOND_ONLY];
		next_st.cfg.crCompare = next_st.fifoMode[M4_CR_CMP];

		// reset is synchronous, so the whole state is loaded here
		if (!reset_n) begin
			next_st = '0;
			next_st.modeOne = MODE_ONE_RST;
			next_st.errorMask = ERROR_MASK_RST;
			next_st.statusMask = STATUS_MASK_RST;
			next_st.fifoMode = FIFO_MODE_RST;
			next_st.cfg.statusIntMask = STATUS_MASK_RST[6:0];
			next_st.cfg.rxThreshold = RX_THR_NORM[0];
			next_st.cfg.txThreshold = TX_THR_NORM[0];
			next_st.cfg.crCompare = 1'b0;
		end
	end

	// single state register
	always_ff @(posedge clk) begin
		st <= next_st;
	end

	// every output is a flip-flop of the state
	assign prdata = st.rdata;
	assign pready = st.ready;
	assign pslverr = st.slvErr;
	assign linkCfg = st.cfg;
	assign matchFlags = st.match;
	assign addressDone = st.addrDone;
	assign txByteCount = st.txCount;
	assign txPush = st.push;
	assign txData = st.pushData;
	assign rxPop = st.pop;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	property p_tx_addr;
		st.cfg.txAddrEnable == st.modeOne[2] && st.cfg.txAddress == st.txAddr;
	endproperty
	a_tx_addr: assert property (p_tx_addr) else $error("transmit address config mismatch");

	property p_match_off;
		addressDone |-> (matchFlags & ~st.modeOne[7:4]) == 4'h0;
	endproperty
	a_match_off: assert property (p_match_off) else $error("disabled pair reported a match");

	property p_reset_vals;
		$rose(reset_n) |-> st.modeOne == 8'h00 && st.errorMask == 8'h00 && st.statusMask == 8'h03;
	endproperty
	a_reset_vals: assert property (p_reset_vals) else $error("mode reset value wrong");

	property p_rx_thr;
		st.extFifo && st.fifoMode[1:0] == 2'h3 |-> linkCfg.rxThreshold == 5'h1e;
	endproperty
	a_rx_thr: assert property (p_rx_thr) else $error("extended receive threshold wrong");

	property p_tx_thr;
		!st.extFifo && st.fifoMode[3:2] == 2'h2 |-> linkCfg.txThreshold == 5'h04;
	endproperty
	a_tx_thr: assert property (p_tx_thr) else $error("normal transmit threshold wrong");

	property p_mask_write;
		wrXfer && hit(wordIdx, IDX_ERROR_MASK) |=> linkCfg.errorIntMask == $past(pwdata[7:0]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("error mask write lost");

	// a write to mode one reaches the interrupt enables on the very next cycle
	property p_mode_one_write;
		wrXfer && hit(wordIdx, IDX_MODE_ONE) |=> linkCfg.txThrIntEn == $past(pwdata[M1_TX_THR_IE])
			&& linkCfg.rxThrIntEn == $past(pwdata[M1_RX_THR_IE]) && linkCfg.eorIntEn == $past(pwdata[M1_EOR_IE]);
	endproperty
	a_mode_one_write: assert property (p_mode_one_write) else $error("mode one interrupt enables wrong");

	property p_status_write;
		wrXfer && hit(wordIdx, IDX_STATUS_MASK) |=> linkCfg.statusIntMask == $past(pwdata[6:0])
			&& linkCfg.fcsToFifo == $past(pwdata[M3_FCS_TO_FIFO]);
	endproperty
	a_status_write: assert property (p_status_write) else $error("status mask write lost");

	// second-byte-only mode ignores the first byte entirely
	property p_second_only;
		addressDone && $past(st.cfg.oneByteAddr) && $past(st.cfg.secondByteOnly)
			|-> matchFlags == ($past(secondEq) & $past(pairEn));
	endproperty
	a_second_only: assert property (p_second_only) else $error("second byte match wrong");

	property p_mode_hold;
		!wrXfer |=> $stable(st.modeOne) && $stable(st.errorMask) && $stable(st.statusMask);
	endproperty
	a_mode_hold: assert property (p_mode_hold) else $error("mode register changed without write");

	property p_push;
		wrXfer && hit(wordIdx, IDX_TX_PORT) |=> txPush && txData == $past(pwdata[7:0]) ##1 !txPush;
	endproperty
	a_push: assert property (p_push) else $error("transmit push wrong");

	property p_count_dec;
		!wrXfer && txByteDone && txByteCount != 16'h0000 |=> txByteCount == $past(txByteCount) - 16'h0001;
	endproperty
	a_count_dec: assert property (p_count_dec) else $error("transmit count did not step");

	property p_ready;
		psel && penable && !pready |=> pready ##1 !pready;
	endproperty
	a_ready: assert property (p_ready) else $error("apb ready timing wrong");

	property p_fill;
		linkCfg.flagIdle == st.fifoMode[4] && linkCfg.fcsToFifo == st.statusMask[7];
	endproperty
	a_fill: assert property (p_fill) else $error("fill or fcs config mismatch");
endmodule

// File: src/dchannel_link_pkg.sv
// constants, register map and carrier types of the link configuration register bank
package dchannel_link_pkg;
	// register word indices; byte address is four times the index
	localparam logic [7:0] IDX_FIRST_MATCH = 8'h81;
	localparam logic [7:0] IDX_SECOND_MATCH = 8'h82;
	localparam logic [7:0] IDX_TX_ADDRESS = 8'h83;
	localparam logic [7:0] IDX_TX_COUNT = 8'h85;
	localparam logic [7:0] IDX_MODE_ONE = 8'h86;
	localparam logic [7:0] IDX_ERROR_MASK = 8'h87;
	localparam logic [7:0] IDX_RX_COUNT = 8'h89;
	localparam logic [7:0] IDX_RANDOM_LOW = 8'h8a;
	localparam logic [7:0] IDX_RANDOM_HIGH = 8'h8b;
	localparam logic [7:0] IDX_FIRST_MATCH_4 = 8'h8c;
	localparam logic [7:0] IDX_SECOND_MATCH_4 = 8'h8d;
	localparam logic [7:0] IDX_STATUS_MASK = 8'h8e;
	localparam logic [7:0] IDX_FIFO_MODE = 8'h8f;
	localparam logic [7:0] IDX_EXT_FIFO = 8'h92;
	localparam logic [7:0] IDX_TX_PORT = 8'h93;
	localparam logic [7:0] IDX_RX_PORT = 8'h94;

	// match pairs; pairs one to three share one indirect word each
	localparam int NUM_PAIRS = 4;
	localparam logic [1:0] SHARED_LAST = 2'h2;

	// link_mode_one fields
	localparam int M1_TX_THR_IE = 0;
	localparam int M1_RX_THR_IE = 1;
	localparam int M1_TX_ADDR_EN = 2;
	localparam int M1_EOR_IE = 3;
	localparam int M1_PAIR_EN = 4;
	// fifo_and_address_mode fields, then the status mask fcs bit
	localparam int M4_RX_THR = 0;
	localparam int M4_TX_THR = 2;
	localparam int M4_FLAG_IDLE = 4;
	localparam int M4_ONE_BYTE = 5;
	localparam int M4_CR_CMP = 6;
	localparam int M4_SECOND_ONLY = 7;
	localparam int M3_FCS_TO_FIFO = 7;

	// reset values
	localparam logic [7:0] MODE_ONE_RST = 8'h00;
	localparam logic [7:0] ERROR_MASK_RST = 8'h00;
	localparam logic [7:0] STATUS_MASK_RST = 8'h03;
	localparam logic [7:0] FIFO_MODE_RST = 8'h00;

	// threshold tables, indexed by the two-bit code
	localparam logic [3:0][4:0] RX_THR_NORM = {5'h08, 5'h04, 5'h02, 5'h01};
	localparam logic [3:0][4:0] RX_THR_EXT = {5'h1e, 5'h18, 5'h10, 5'h01};
	localparam logic [3:0][4:0] TX_THR_NORM = {5'h08, 5'h04, 5'h02, 5'h01};
	localparam logic [3:0][4:0] TX_THR_EXT = {5'h0e, 5'h0a, 5'h06, 5'h01};

	// first-byte compare masks: bit 1 is the command/response bit
	localparam logic [7:0] CR_MASK_ON = 8'hff;
	localparam logic [7:0] CR_MASK_OFF = 8'hfd;
	// random generator feedback taps
	localparam logic [15:0] RNG_TAPS = 16'hd008;

	// decoded configuration handed to the link controller
	typedef struct packed {
		logic txThrIntEn;
		logic rxThrIntEn;
		logic eorIntEn;
		logic txAddrEnable;
		logic [15:0] txAddress;
		logic [7:0] errorIntMask;
		logic [6:0] statusIntMask;
		logic fcsToFifo;
		logic [4:0] rxThreshold;
		logic [4:0] txThreshold;
		logic flagIdle;
		logic oneByteAddr;
		logic secondByteOnly;
		logic crCompare;
	} link_cfg_t;

	// one received address byte from the link controller
	typedef struct packed {
		logic valid;
		logic second;
		logic [7:0] data;
	} rx_addr_byte_t;
endpackage

// File: dv/testbench.sv
// self-checking testbench for the link configuration register bank
`timescale 1ns/100ps
module testbench;
	import dchannel_link_pkg::*;
	logic clk, resetN, psel, penable, pwrite, pready, pslverr, txByteDone, txPush, rxPop, addressDone, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd, r0, rnd;
	logic [15:0] rxByteCount, txByteCount;
	logic [7:0] rxFifoData, txData, fb, sb;
	logic [3:0] matchFlags;
	rx_addr_byte_t rxAddrByte;
	link_cfg_t linkCfg;
	int nErrors, numChecks, fp, sp, i, j, k;
	integer seed;
	logic extMode;
	logic [15:0] mreg [0:255];
	logic [7:0] fr [0:3];
	logic [7:0] sr [0:3];
	int rxe [4] = '{1, 16, 24, 30};
	int txe [4] = '{1, 6, 10, 14};
	int nrm [4] = '{1, 2, 4, 8};
	logic [7:0] ids [8] = '{8'h83, 8'h85, 8'h86, 8'h87, 8'h8e, 8'h8f, 8'h8c, 8'h8d};
	logic [7:0] amode [4] = '{8'h00, 8'h20, 8'ha0, 8'h40};

	dchannel_link_config_regs #(.ADDR_W(12)) dut_u (.clk(clk), .reset_n(resetN), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .rxAddrByte(rxAddrByte), .rxByteCount(rxByteCount),
		.rxFifoData(rxFifoData), .txByteDone(txByteDone), .linkCfg(linkCfg), .matchFlags(matchFlags),
		.addressDone(addressDone), .txByteCount(txByteCount), .txPush(txPush), .txData(txData),
		.rxPop(rxPop));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic chkCfg(input link_cfg_t exp);
		numChecks++;
		if (linkCfg !== exp) begin
			nErrors++;
			$display("ERROR linkCfg expected %h seen %h", exp, linkCfg);
		end
	endtask

	task automatic completeRun;
		$display("checks %0d mismatches %0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// model state after any reset; shared pair pointers restart at pair one
	task automatic resetModel;
		foreach (mreg[n]) mreg[n] = 16'h0000;
		mreg[8'h8e] = 16'h0003;
		foreach (fr[n]) fr[n] = 8'h00;
		foreach (sr[n]) sr[n] = 8'h00;
		fp = 0;
		sp = 0;
		extMode = 1'b0;
	endtask

	// expected decoded configuration from the model registers
	function automatic link_cfg_t cfgModel();
		link_cfg_t c;
		logic [7:0] m1, m3, m4;
		m1 = mreg[8'h86][7:0];
		m3 = mreg[8'h8e][7:0];
		m4 = mreg[8'h8f][7:0];
		c.txThrIntEn = m1[0];
		c.rxThrIntEn = m1[1];
		c.txAddrEnable = m1[2];
		c.eorIntEn = m1[3];
		c.txAddress = mreg[8'h83];
		c.errorIntMask = mreg[8'h87][7:0];
		c.statusIntMask = m3[6:0];
		c.fcsToFifo = m3[7];
		c.rxThreshold = 5'(extMode ? rxe[m4[1:0]] : nrm[m4[1:0]]);
		c.txThreshold = 5'(extMode ? txe[m4[3:2]] : nrm[m4[3:2]]);
		c.flagIdle = m4[4];
		c.oneByteAddr = m4[5];
		c.crCompare = m4[6];
		c.secondByteOnly = m4[7];
		return c;
	endfunction

	// apb master: request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] d, output logic e);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			nErrors++;
			$display("ERROR pready expected 1 seen %b", pready);
			completeRun();
		end
		d = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// one register access checked against the model, then pulses and configuration
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
		logic [31:0] exp;
		logic bad, cmp;
		bad = 1'b0;
		cmp = !wr;
		exp = 32'h0000_0000;
		case (idx)
			8'h81: exp = {24'h00_0000, fr[fp]};
			8'h82: exp = {24'h00_0000, sr[sp]};
			8'h8c: exp = {24'h00_0000, fr[3]};
			8'h8d: exp = {24'h00_0000, sr[3]};
			8'h83, 8'h85: exp = {16'h0000, mreg[idx]};
			8'h86, 8'h87, 8'h8e, 8'h8f: exp = {24'h00_0000, mreg[idx][7:0]};
			8'h89: exp = {16'h0000, rxByteCount};
			8'h94: exp = {24'h00_0000, rxFifoData};
			8'h93: exp = 32'h0000_0000;
			8'h8a, 8'h8b, 8'h92: cmp = 1'b0;
			default: bad = 1'b1;
		endcase
		apb(wr, {2'b00, idx, 2'b00}, wd, rd, err);
		chk("pslverr", 32'(bad), 32'(err));
		if (cmp || bad) chk("prdata", exp, rd);
		if (wr) begin
			case (idx)
				8'h81: fr[fp] = wd[7:0];
				8'h82: sr[sp] = wd[7:0];
				8'h8c: fr[3] = wd[7:0];
				8'h8d: sr[3] = wd[7:0];
				8'h83, 8'h85: mreg[idx] = wd[15:0];
				8'h86, 8'h87, 8'h8e, 8'h8f: mreg[idx] = {8'h00, wd[7:0]};
				8'h92: extMode = wd[0];
				default: ;
			endcase
		end
		if (idx == 8'h81) fp = (fp + 1) % 3;
		if (idx == 8'h82) sp = (sp + 1) % 3;
		@(negedge clk);
		chk("txPush", 32'(wr && idx == 8'h93), 32'(txPush));
		if (txPush === 1'b1) chk("txData", {24'h00_0000, wd[7:0]}, {24'h00_0000, txData});
		chk("rxPop", 32'(!wr && idx == 8'h94), 32'(rxPop));
		@(negedge clk);
		chkCfg(cfgModel());
		chk("txByteCount", {16'h0000, mreg[8'h85]}, {16'h0000, txByteCount});
	endtask

	// two address bytes; the model decides which enabled pairs recognise them
	task automatic sendAddr(input logic [7:0] f, input logic [7:0] s);
		logic [3:0] exp;
		logic [7:0] m, m4;
		m4 = mreg[8'h8f][7:0];
		m = m4[6] ? 8'hff : 8'hfd;
		for (int p = 0; p < 4; p++) begin
			exp[p] = mreg[8'h86][4 + p] && (m4[5] ? (m4[7] ? s == sr[p] : (f & m) == (fr[p] & m))
				: ((f & m) == (fr[p] & m) && s == sr[p]));
		end
		@(posedge clk);
		rxAddrByte <= '{1'b1, 1'b0, f};
		@(posedge clk);
		rxAddrByte <= '{1'b1, 1'b1, s};
		@(negedge clk);
		chk("matchFlags cleared", 32'h0000_0000, {28'h000_0000, matchFlags});
		@(posedge clk);
		rxAddrByte <= '0;
		@(negedge clk);
		chk("addressDone", 32'h0000_0001, 32'(addressDone));
		chk("matchFlags", {28'h000_0000, exp}, {28'h000_0000, matchFlags});
		@(negedge clk);
		chk("addressDone low", 32'h0000_0000, 32'(addressDone));
	endtask

	task automatic txDone;
		@(posedge clk);
		txByteDone <= 1'b1;
		@(posedge clk);
		txByteDone <= 1'b0;
		if (mreg[8'h85] != 16'h0000) mreg[8'h85] = mreg[8'h85] - 16'h0001;
	endtask

	// main sequence
	initial begin
		seed = 32'hdbbb_3468;
		nErrors = 0;
		numChecks = 0;
		{psel, penable, pwrite, txByteDone} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		rxAddrByte = '0;
		rxByteCount = 16'h0000;
		rxFifoData = 8'h00;
		resetModel();
		resetN = 1'b0;
		repeat (8) @(posedge clk);
		resetN <= 1'b1;
		for (i = 2; i < 6; i++) xfer(1'b0, ids[i], 32'h0000_0000);
		chk("matchFlags reset", 32'h0000_0000, {28'h000_0000, matchFlags});
		$display("reset test done");
		for (j = 0; j < 4; j++) begin
			for (i = 0; i < 8; i++) begin
				xfer(1'b1, ids[i], $random(seed));
				xfer(1'b0, ids[i], 32'h0000_0000);
			end
		end
		// pairs one to three share a word; three accesses walk through them
		for (i = 0; i < 6; i++) xfer(1'b1, 8'h81 + 8'(i % 2), $random(seed));
		for (i = 0; i < 6; i++) xfer(1'b0, 8'h81 + 8'(i % 2), 32'h0000_0000);
		$display("register test done");
		for (j = 0; j < 2; j++) begin
			xfer(1'b1, 8'h92, 32'(j));
			for (i = 0; i < 4; i++) xfer(1'b1, 8'h8f, 32'(i * 3 + 3));
		end
		$display("threshold test done");
		for (i = 0; i < 32; i++) begin
			xfer(1'b1, 8'h8f, {24'h00_0000, amode[i % 4]});
			xfer(1'b1, 8'h86, i < 16 ? 32'h0000_00f0 : $random(seed));
			rnd = $random(seed);
			k = int'(rnd[5:4]);
			fb = fr[k] ^ {3'h0, rnd[3] & rnd[2], 2'h0, rnd[0], 1'b0};
			sb = sr[k] ^ {7'h00, rnd[1] & rnd[2]};
			sendAddr(fb, sb);
		end
		$display("address test done");
		xfer(1'b1, 8'h85, 32'h0000_0003);
		repeat (4) txDone();
		xfer(1'b0, 8'h85, 32'h0000_0000);
		for (i = 0; i < 3; i++) begin
			@(posedge clk);
			rxFifoData <= 8'($random(seed));
			rxByteCount <= 16'($random(seed));
			xfer(1'b1, 8'h93, $random(seed));
			xfer(1'b0, 8'h94, 32'h0000_0000);
			xfer(1'b0, 8'h93, 32'h0000_0000);
			xfer(1'b1, 8'h94, $random(seed));
			xfer(1'b1, 8'h89, $random(seed));
			xfer(1'b0, 8'h89, 32'h0000_0000);
		end
		$display("count and port test done");
		// the generator keeps running, so two reads of the same word must differ
		xfer(1'b1, 8'h8a, $random(seed));
		xfer(1'b1, 8'h8b, $random(seed));
		apb(1'b0, 12'h228, 32'h0000_0000, r0, err);
		apb(1'b0, 12'h228, 32'h0000_0000, rd, err);
		chk("random moves", 32'h0000_0001, 32'(r0 !== rd));
		xfer(1'b0, 8'h80, 32'h0000_0000);
		xfer(1'b1, 8'h95, $random(seed));
		apb(1'b0, 12'h219, 32'h0000_0000, rd, err);
		chk("misaligned pslverr", 32'h0000_0001, 32'(err));
		chk("misaligned prdata", 32'h0000_0000, rd);
		$display("error test done");
		xfer(1'b1, 8'h86, 32'h0000_00ff);
		xfer(1'b1, 8'h8e, 32'h0000_0000);
		@(posedge clk);
		resetN <= 1'b0;
		repeat (8) @(posedge clk);
		resetN <= 1'b1;
		resetModel();
		for (i = 0; i < 8; i++) xfer(1'b0, ids[i], 32'h0000_0000);
		chk("matchFlags after reset", 32'h0000_0000, {28'h000_0000, matchFlags});
		$display("second reset test done");
		completeRun();
	end
endmodule
